//--- cpc_defines.svh
// Purpose: Constants for the charge pump controller
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes: Offsets are byte addresses
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH
// 0x020D is not a multiple of four, so it is an index
`define CPC_CTRL_INDEX 12'h20D
`define CPC_CTRL_ADDR 14'h0834
`define CPC_IRQ_STATUS_ADDR 14'h0840
`define CPC_IRQ_MASK_ADDR 14'h0844
`define CPC_ADDR_W 14
`define CPC_CTRL_RESET 8'h00
`define CPC_MODE_HI 7
`define CPC_MODE_LO 6
`define CPC_OSC_SEL_BIT 5
`define CPC_REQ_BIT 2
`define CPC_ABOVE_BIT 1
`define CPC_READY_BIT 0
`define CPC_IRQ_W 3
`define CPC_IRQ_READY 0
`define CPC_IRQ_THRESH 1
`define CPC_IRQ_REQ 2
`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2
`endif

//--- cpc_pkg.sv
// Purpose: Types for the charge pump controller
// Assumes: Constants live in cpc_defines.svh
// Notes: Mode codes follow the enable field encoding
package cpc_pkg;
    typedef enum logic [1:0] {
        CPC_MODE_OFF = 2'h0,
        CPC_MODE_PERIPH = 2'h1,
        CPC_MODE_SUPPLY = 2'h2,
        CPC_MODE_ON = 2'h3
    } cpc_mode_e;
    typedef enum logic [1:0] {
        CPC_CLK_ADC_RC = 2'h0,
        CPC_CLK_SYS_DIV = 2'h1,
        CPC_CLK_INTERNAL = 2'h2
    } cpc_clk_src_e;
endpackage

//--- cpc_sync.sv
// Purpose: Two-flop synchroniser for analog levels
// Assumes: Inputs are slow levels
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module cpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end
    assign sync_out = stage2_reg;
endmodule

//--- cpc_pump_ctrl.sv
// Purpose: Pump enable and clock source decision
// Assumes: Inputs already on aclk
// Notes: Registered outputs, one cycle after cause
`include "cpc_defines.svh"
`timescale 1ns/1ps
module cpc_pump_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic [1:0] pump_enable_mode,
    input wire logic pump_osc_select,
    // Conditions
    input wire logic supply_above_threshold,
    input wire logic adc_power_on,
    input wire logic adc_conversion_active,
    // Results
    output logic pump_on,
    output cpc_pkg::cpc_clk_src_e pump_clk_src
);
    logic pump_on_next;
    cpc_pkg::cpc_clk_src_e clk_next;
    logic below;
    assign below = !supply_above_threshold;
    always_comb begin
        case (cpc_pkg::cpc_mode_e'(pump_enable_mode))
            cpc_pkg::CPC_MODE_ON: pump_on_next = 1'b1;
            cpc_pkg::CPC_MODE_SUPPLY: pump_on_next = below;
            cpc_pkg::CPC_MODE_PERIPH: pump_on_next = adc_power_on && below;
            default: pump_on_next = 1'b0;
        endcase
    end
    assign clk_next = pump_osc_select ? cpc_pkg::CPC_CLK_INTERNAL :
        (adc_conversion_active ? cpc_pkg::CPC_CLK_SYS_DIV :
        cpc_pkg::CPC_CLK_ADC_RC);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pump_on <= 1'b0;
            pump_clk_src <= cpc_pkg::CPC_CLK_ADC_RC;
        end else begin
            pump_on <= pump_on_next;
            pump_clk_src <= clk_next;
        end
    end
endmodule

//--- cpc_top.sv
// Purpose: Charge pump controller with AXI4-Lite register slave
// Assumes: Analog flags arrive asynchronously; ADC state is on aclk
// Notes: Sticky status events raise a level interrupt
//
// Local design decision: the AXI4-Lite register port.
`include "cpc_defines.svh"
`timescale 1ns/1ps
module cpc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [`CPC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [`CPC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog inputs, asynchronous
    input wire logic supply_above_threshold,
    input wire logic pump_steady,
    // ADC state, on aclk
    input wire logic adc_power_on,
    input wire logic adc_conversion_active,
    input wire logic analog_pump_request,
    // Pump controls
    output logic pump_enable,
    output logic [2:0] pump_clk_sel,
    // Interrupt
    output logic irq
);
    // Storage
    logic [1:0] mode_reg;
    logic osc_sel_reg;
    logic [`CPC_IRQ_W-1:0] irq_status_reg;
    logic [`CPC_IRQ_W-1:0] irq_status_next;
    logic [`CPC_IRQ_W-1:0] irq_mask_reg;
    logic [`CPC_IRQ_W-1:0] flags_prev_reg;
    logic [`CPC_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    // Synchronised analog flags
    logic [1:0] analog_sync;
    logic above_s;
    logic steady_s;
    logic pump_on;
    cpc_pkg::cpc_clk_src_e clk_src;

    cpc_sync #(.W(2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({supply_above_threshold, pump_steady}),
        .sync_out(analog_sync)
    );
    assign above_s = analog_sync[1];
    assign steady_s = analog_sync[0];

    cpc_pump_ctrl u_ctrl (
        .aclk(aclk),
        .aresetn(aresetn),
        .pump_enable_mode(mode_reg),
        .pump_osc_select(osc_sel_reg),
        .supply_above_threshold(above_s),
        .adc_power_on(adc_power_on),
        .adc_conversion_active(adc_conversion_active),
        .pump_on(pump_on),
        .pump_clk_src(clk_src)
    );
    assign pump_enable = pump_on;
    // One-hot: bit 0 ADC RC, bit 1 divided system clock, bit 2 internal
    assign pump_clk_sel = {clk_src == cpc_pkg::CPC_CLK_INTERNAL,
        clk_src == cpc_pkg::CPC_CLK_SYS_DIV, clk_src == cpc_pkg::CPC_CLK_ADC_RC};

    // Ready only counts while the pump is on, so a stale analog flag cannot show
    logic ready_flag;
    assign ready_flag = steady_s && pump_on;

    // Control register image
    logic [7:0] ctrl_image;
    assign ctrl_image = {mode_reg, osc_sel_reg, 2'h0,
        analog_pump_request, above_s, ready_flag};

    // Write channel: take address and data in either order
    logic aw_fire;
    logic w_fire;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic [`CPC_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign have_aw = aw_held_reg || aw_fire;
    assign have_w = w_held_reg || w_fire;
    assign do_write = have_aw && have_w && !bvalid_reg;
    assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;

    function automatic logic addr_is(input logic [`CPC_ADDR_W-1:0] a, input logic [`CPC_ADDR_W-1:0] ref_a);
        addr_is = (a[`CPC_ADDR_W-1:2] == ref_a[`CPC_ADDR_W-1:2]);
    endfunction

    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_hit;
    assign wr_ctrl = do_write && addr_is(wr_addr, `CPC_CTRL_ADDR) && wr_strb[0];
    assign wr_status = do_write && addr_is(wr_addr, `CPC_IRQ_STATUS_ADDR) && wr_strb[0];
    assign wr_mask = do_write && addr_is(wr_addr, `CPC_IRQ_MASK_ADDR) && wr_strb[0];
    assign wr_hit = addr_is(wr_addr, `CPC_CTRL_ADDR) || addr_is(wr_addr, `CPC_IRQ_STATUS_ADDR)
        || addr_is(wr_addr, `CPC_IRQ_MASK_ADDR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            aw_held_reg <= have_aw && !do_write;
            w_held_reg <= have_w && !do_write;
            if (aw_fire) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `CPC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Only the writable fields are stored; status bits come from live state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= 2'(`CPC_CTRL_RESET >> `CPC_MODE_LO);
            osc_sel_reg <= 1'b0;
            irq_mask_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                mode_reg <= wr_data[`CPC_MODE_HI:`CPC_MODE_LO];
                osc_sel_reg <= wr_data[`CPC_OSC_SEL_BIT];
            end
            if (wr_mask) begin
                irq_mask_reg <= wr_data[`CPC_IRQ_W-1:0];
            end
        end
    end

    // Events: ready rises, threshold flag changes, request rises
    logic [`CPC_IRQ_W-1:0] flags_now;
    logic [`CPC_IRQ_W-1:0] events;
    assign flags_now = {analog_pump_request, above_s, ready_flag};
    assign events = {flags_now[`CPC_IRQ_REQ] && !flags_prev_reg[`CPC_IRQ_REQ],
        flags_now[`CPC_IRQ_THRESH] ^ flags_prev_reg[`CPC_IRQ_THRESH],
        flags_now[`CPC_IRQ_READY] && !flags_prev_reg[`CPC_IRQ_READY]};
    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_status) begin
            irq_status_next = irq_status_reg & ~wr_data[`CPC_IRQ_W-1:0];
        end
        irq_status_next = irq_status_next | events;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_prev_reg <= '0;
            irq_status_reg <= '0;
        end else begin
            flags_prev_reg <= flags_now;
            irq_status_reg <= irq_status_next;
        end
    end
    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read channel: one cycle to answer
    logic ar_fire;
    logic rd_ctrl;
    logic rd_status;
    logic rd_mask;
    logic [31:0] rd_word;
    assign s_axi_arready = !rvalid_reg;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign rd_ctrl = addr_is(s_axi_araddr, `CPC_CTRL_ADDR);
    assign rd_status = addr_is(s_axi_araddr, `CPC_IRQ_STATUS_ADDR);
    assign rd_mask = addr_is(s_axi_araddr, `CPC_IRQ_MASK_ADDR);
    assign rd_word = rd_ctrl ? {24'h0, ctrl_image} :
        rd_status ? {29'h0, irq_status_reg} :
        rd_mask ? {29'h0, irq_mask_reg} : 32'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `CPC_RESP_OKAY;
            rdata_reg <= 32'h0;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= (rd_ctrl || rd_status || rd_mask) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

//--- cpc_asserts.sv
// Purpose: Port-level checks of the charge pump controller
// Assumes: One clock, synchronous active-low reset
// Notes: Mode is internal, so pump decisions are judged by the bench
`include "cpc_defines.svh"
`timescale 1ns/1ps
module cpc_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pump
    input wire logic adc_conversion_active,
    input wire logic pump_enable,
    input wire logic [2:0] pump_clk_sel
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    clk_onehot_a: assert property ($onehot(pump_clk_sel))
        else $error("pump clock select not one-hot");
    reset_state_a: assert property ($rose(aresetn) |-> !pump_enable && pump_clk_sel == 3'h1)
        else $error("pump not off after reset");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write answer late");
    arready_rule_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    conv_clock_a: assert property ($past(aresetn) && !pump_clk_sel[2]
        |-> pump_clk_sel[1] == $past(adc_conversion_active))
        else $error("pump clock does not follow conversion");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (pump_enable && pump_clk_sel[1]);
    cover property ($rose(pump_enable));
endmodule

//--- charge_pump_controller_bench.sv
// Purpose: Self-checking bench of the charge pump controller
// Assumes: Bench drives all ports over AXI4-Lite and level inputs
// Notes: Inputs are held steady around each check so sync delay is known
`include "cpc_defines.svh"
`timescale 1ns/1ps
module charge_pump_controller_bench;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, supply_above_threshold = 1'b1, pump_steady = 1'b0;
    logic adc_power_on = 1'b0, adc_conversion_active = 1'b0, analog_pump_request = 1'b0;
    logic [`CPC_ADDR_W-1:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pump_enable, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] pump_clk_sel;
    int bad_count = 0, n_checks = 0;
    cpc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_above_threshold,
        .pump_steady, .adc_power_on, .adc_conversion_active, .analog_pump_request, .pump_enable, .pump_clk_sel, .irq);
    always #20 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Irq is looked at mid-cycle, away from the edge that updates it
    task automatic chk_irq(input logic e);
        @(negedge aclk);
        chk(32'(irq), 32'(e));
        @(posedge aclk);
    endtask
    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Called at a rising edge; releases each channel only after its handshake edge
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        logic at, wt, bt;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            at = s_axi_awvalid && s_axi_awready;
            wt = s_axi_wvalid && s_axi_wready;
            bt = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (at) s_axi_awvalid <= 1'b0;
            if (wt) s_axi_wvalid <= 1'b0;
        end while (!bt);
        s_axi_bready <= 1'b0;
        chk(32'(r), 32'(e));
        // An edge passes so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] e);
        logic at, rt;
        logic [33:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            at = s_axi_arvalid && s_axi_arready;
            rt = s_axi_rvalid;
            r = {s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (at) s_axi_arvalid <= 1'b0;
        end while (!rt);
        s_axi_rready <= 1'b0;
        chk(r[31:0], ed);
        chk(32'(r[33:32]), 32'(e));
        // An edge passes so a following call never re-raises rready in this step
        @(posedge aclk);
    endtask
    function automatic logic exp_pe(input logic [1:0] m, input logic up, input logic on);
        case (m)
            2'h3: return 1'b1;
            2'h2: return !up;
            2'h1: return on && !up;
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        conclude();
    end
    initial begin
        logic [1:0] m;
        logic sl, up, pe;
        logic [31:0] d;
        void'($urandom(71));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(32'({pump_enable, pump_clk_sel}), 32'h1);
        // The synchronised supply flag needs two edges after release to show
        repeat (3) @(posedge aclk);
        rd(`CPC_CTRL_ADDR, 32'h2, 2'h0);
        rd(14'h0838, 32'h0, `CPC_RESP_SLVERR);
        wr(14'h0838, 32'hFF, 4'hF, `CPC_RESP_SLVERR);
        wr(`CPC_CTRL_ADDR, 32'hFF, 4'hE, 2'h0);
        rd(`CPC_CTRL_ADDR, 32'h2, 2'h0);
        for (int i = 0; i < 48; i++) begin
            m = (i < 8) ? i[1:0] : 2'($urandom);
            sl = 1'($urandom);
            up = 1'($urandom);
            d = $urandom;
            d[7:5] = {m, sl};
            adc_power_on <= 1'($urandom);
            adc_conversion_active <= 1'($urandom);
            analog_pump_request <= 1'($urandom);
            pump_steady <= 1'($urandom);
            wr(`CPC_CTRL_ADDR, d, 4'hF, 2'h0);
            pe = exp_pe(m, supply_above_threshold, adc_power_on);
            supply_above_threshold <= up;
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            chk(32'(pump_enable), 32'(pe));
            @(posedge aclk);
            @(negedge aclk);
            pe = exp_pe(m, up, adc_power_on);
            chk(32'(pump_enable), 32'(pe));
            chk(32'(pump_clk_sel), sl ? 32'h4 : (adc_conversion_active ? 32'h2 : 32'h1));
            @(posedge aclk);
            d = {24'h0, m, sl, 2'h0, analog_pump_request, up, pump_steady & pe};
            rd(`CPC_CTRL_ADDR, d, 2'h0);
        end
        analog_pump_request <= 1'b0;
        pump_steady <= 1'b0;
        supply_above_threshold <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(`CPC_IRQ_STATUS_ADDR, 32'h7, 4'hF, 2'h0);
        wr(`CPC_IRQ_MASK_ADDR, 32'h2, 4'hF, 2'h0);
        chk_irq(1'b0);
        supply_above_threshold <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(`CPC_IRQ_STATUS_ADDR, 32'h2, 2'h0);
        chk_irq(1'b1);
        wr(`CPC_IRQ_MASK_ADDR, 32'h0, 4'hF, 2'h0);
        chk_irq(1'b0);
        wr(`CPC_IRQ_MASK_ADDR, 32'h2, 4'hF, 2'h0);
        chk_irq(1'b1);
        wr(`CPC_IRQ_STATUS_ADDR, 32'h2, 4'hF, 2'h0);
        chk_irq(1'b0);
        conclude();
    end
endmodule
bind cpc_top cpc_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .adc_conversion_active, .pump_enable, .pump_clk_sel);
